// ---- design/tmz_pkg.sv ----
/*
  package for the timer0 block: register offsets, field positions,
  reset values and timing constants.
  assumes a plain strobe register port and a single 125 MHz clock.
*/
package tmz_pkg;
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] TMZ_OFS_COUNT = 8'h01;
  localparam logic [7:0] TMZ_OFS_INTCTL = 8'h0B;
  localparam logic [7:0] TMZ_OFS_OPTION = 8'h81;
  localparam logic [7:0] TMZ_OFS_IRQ_STAT = 8'hC0;
  localparam logic [7:0] TMZ_OFS_IRQ_MASK = 8'hC1;
  // option field positions
  localparam int TMZ_OPT_CS = 5;
  localparam int TMZ_OPT_SE = 4;
  localparam int TMZ_OPT_PSA = 3;
  localparam int TMZ_OPT_PS_LO = 0;
  // interrupt control field positions
  localparam int TMZ_IC_FLAG = 2;
  localparam int TMZ_IC_EN = 5;
  // reset values
  localparam logic [7:0] TMZ_OPTION_RST = 8'hFF;
  localparam logic [7:0] TMZ_INTCTL_RST = 8'h00;
  localparam logic [7:0] TMZ_COUNT_RST = 8'h00;
  localparam logic [7:0] TMZ_ZERO8 = 8'h00;
  localparam logic [7:0] TMZ_ONES8 = 8'hFF;
  // instruction cycle is four phases of the clock
  localparam logic [1:0] TMZ_PHASE_LAST = 2'h3;
  localparam logic [1:0] TMZ_PHASE_Q2 = 2'h1;
  localparam logic [1:0] TMZ_PHASE_Q4 = 2'h3;
  localparam logic [1:0] TMZ_INHIBIT_CYCLES = 2'h2;
  // pin path to the register view, and the state of the block
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmz_bus_t;
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] intctl;
    logic [7:0] option;
    logic [7:0] prescale;
    logic [1:0] phase;
    logic [1:0] inhibit;
    logic ext_s1;
    logic ext_s2;
    logic ps_out_q2;
    logic ps_out_q4;
    logic ps_prev;
    logic [7:0] rdata;
    logic irq;
    logic wdt_tick;
    logic irq_stat;
    logic irq_mask;
    logic irq_any;
  } tmz_state_t;
endpackage

// ---- design/tmz_timer0.sv ----
/*
  timer0 block: an 8-bit timer/counter with a divider shared with the
  watchdog, the register view, the interrupt levels and the guard
  assertions.
  assumes the core drives the plain register port on clk_i, one strobe
  per cycle, that sleep_i and watchdog_clear_instr_i are synchronous to
  clk_i, and that the watchdog itself sits outside and takes
  watchdog_tick_o as its step.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
// What this block does
// R1: overflow from all ones sets the flag
// R2: timer mode counts each instruction cycle
// R3: write to count stalls two cycles
// R4: counter mode counts chosen edge of pin
// R5: sample prescaler output on phases two, four
// R6: unassigned prescaler passes pin straight through
// R7: one prescaler, timer or watchdog
// R8: prescaler count not software accessible
// R9: rate field decodes per user
// R10: count write clears timer prescaler
// R11: watchdog clear clears watchdog prescaler
// R12: request needs flag and enable
// R13: software clears flag before re-enabling
// R14: timer stopped during sleep
// R15: software uses safe reassignment sequence
// R16: prescaler is 8-bit free-running divider
module tmz_timer0 import tmz_pkg::*; #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // external count pin and core controls
  input wire logic ext_count_input_i,
  input wire logic sleep_i,
  input wire logic watchdog_clear_instr_i,
  // outputs
  output logic timer_irq_o,
  output logic watchdog_tick_o,
  output logic irq_o
);
  initial begin
    if (CNT_W != 8) $error("count width must be 8");
  end

  logic [1:0] rst_sync_reg;
  logic rst_n;
  tmz_state_t st_reg, st_next;
  tmz_bus_t bus;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // timer tap: rate code n picks stage n, a division of two to the n plus one
  function automatic logic timer_tap(input logic [7:0] pre, input logic [2:0] rate);
    timer_tap = pre[rate];
  endfunction

  // watchdog wrap: code n lets one step in two to the n through, code 0 each step
  function automatic logic wdt_wrap(input logic [7:0] stepped, input logic [2:0] rate);
    logic [7:0] low_mask;
    low_mask = ~(TMZ_ONES8 << rate);
    wdt_wrap = (stepped & low_mask) == TMZ_ZERO8;
  endfunction

  // address decode shared by the write paths and the status clear; the read mux decodes the address itself
  function automatic logic reg_hit(input tmz_bus_t b, input logic [7:0] ofs);
    reg_hit = b.addr == ofs;
  endfunction

  logic cs, se, prescaler_assign;
  logic [2:0] ps;
  logic in_q2, in_q4, cyc_end;
  logic src_lvl, src_rise, pre_step, clr_pre, ps_out, tick, wr_count, ovf, wdt_step;
  logic [7:0] pre_inc;

  // next state of the whole block
  always_comb begin
    st_next = st_reg;
    // option fields and the phase of the instruction cycle
    cs = st_reg.option[TMZ_OPT_CS];
    se = st_reg.option[TMZ_OPT_SE];
    prescaler_assign = st_reg.option[TMZ_OPT_PSA];
    ps = st_reg.option[TMZ_OPT_PS_LO +: 3];
    in_q2 = st_reg.phase == TMZ_PHASE_Q2;
    in_q4 = st_reg.phase == TMZ_PHASE_Q4;
    cyc_end = st_reg.phase == TMZ_PHASE_LAST;
    wr_count = bus.wr && reg_hit(bus, TMZ_OFS_COUNT);
    // pin synchroniser: only the second flop feeds the logic
    st_next.ext_s1 = ext_count_input_i;
    st_next.ext_s2 = st_reg.ext_s1;
    st_next.phase = st_reg.phase + 2'h1;
    // edge select folds a falling edge into a rising one
    src_lvl = st_reg.ext_s2 ^ se; // R4
    src_rise = src_lvl && !st_reg.ps_prev; // R4
    st_next.ps_prev = src_lvl;
    // prescaler input: the timer source while the timer owns it
    if (prescaler_assign) begin
      pre_step = cyc_end; // R7
    end else if (cs) begin
      pre_step = src_rise; // R4
    end else begin
      pre_step = cyc_end; // R2
    end
    // count writes clear it for the timer, a watchdog clear for the watchdog
    clr_pre = (!prescaler_assign && wr_count) || (prescaler_assign && watchdog_clear_instr_i); // R10 R11
    pre_inc = st_reg.prescale + 8'h01;
    // free-running divider; no register path reads or writes it
    if (clr_pre) begin
      st_next.prescale = TMZ_ZERO8; // R16 R8
    end else if (pre_step) begin
      st_next.prescale = pre_inc; // R16
    end
    // watchdog gets one step per instruction cycle while the timer holds the prescaler
    wdt_step = !clr_pre && pre_step && wdt_wrap(pre_inc, ps); // R9
    st_next.wdt_tick = prescaler_assign ? wdt_step : cyc_end; // R7
    // prescaler output, or the folded pin itself when the watchdog owns it
    if (prescaler_assign) begin
      ps_out = src_lvl; // R6
    end else begin
      ps_out = timer_tap(st_reg.prescale, ps); // R9
    end
    // sample at the second and fourth phase; a rise between samples is one count
    // pulses shorter than two clocks may slip between the samples
    tick = 1'b0;
    if (in_q2) begin
      st_next.ps_out_q2 = ps_out; // R5
      tick = ps_out && !st_reg.ps_out_q4;
    end
    if (in_q4) begin
      st_next.ps_out_q4 = ps_out; // R5
      tick = ps_out && !st_reg.ps_out_q2;
    end
    // timer mode without prescaler steps once per instruction cycle
    if (!cs && prescaler_assign) begin
      tick = cyc_end; // R2
    end
    // inhibit runs down in whole instruction cycles after a count write
    if (st_reg.inhibit != 2'h0 && cyc_end) begin
      st_next.inhibit = st_reg.inhibit - 2'h1; // R3
    end
    // a step that falls in the inhibit or in sleep is lost, not deferred
    ovf = 1'b0;
    if (wr_count) begin
      st_next.count = bus.wdata;
      st_next.inhibit = TMZ_INHIBIT_CYCLES; // R3
    end else if (tick && st_reg.inhibit == 2'h0 && !sleep_i) begin // R3 R14
      st_next.count = st_reg.count + 8'h01; // R2 R4
      ovf = st_reg.count == TMZ_ONES8; // R1
    end
    // register writes; a new edge select may itself look like an edge
    if (bus.wr && reg_hit(bus, TMZ_OFS_OPTION)) begin
      st_next.option = bus.wdata; // R7
    end
    if (bus.wr && reg_hit(bus, TMZ_OFS_INTCTL)) begin
      st_next.intctl = bus.wdata; // R13
    end
    if (bus.wr && reg_hit(bus, TMZ_OFS_IRQ_MASK)) begin
      st_next.irq_mask = bus.wdata[0];
    end
    // hardware set of the flag wins over a software write in the same cycle
    if (ovf) begin
      st_next.intctl[TMZ_IC_FLAG] = 1'b1; // R1 R13
    end
    // read data stand one cycle, zero otherwise
    st_next.rdata = TMZ_ZERO8;
    if (bus.rd) begin
      unique case (bus.addr)
        TMZ_OFS_COUNT: st_next.rdata = st_reg.count;
        TMZ_OFS_INTCTL: st_next.rdata = st_reg.intctl;
        TMZ_OFS_OPTION: st_next.rdata = st_reg.option;
        TMZ_OFS_IRQ_STAT: st_next.rdata = {7'h00, st_reg.irq_stat};
        TMZ_OFS_IRQ_MASK: st_next.rdata = {7'h00, st_reg.irq_mask};
        default: st_next.rdata = TMZ_ZERO8; // R8
      endcase
      // a read of the status clears it
      if (reg_hit(bus, TMZ_OFS_IRQ_STAT)) begin
        st_next.irq_stat = 1'b0;
      end
    end
    // overflow in the cycle of the clearing read still wins
    if (ovf) begin
      st_next.irq_stat = 1'b1;
    end
    // both interrupt levels are registered so the pins come from flops
    st_next.irq = st_next.intctl[TMZ_IC_FLAG] && st_next.intctl[TMZ_IC_EN]; // R12
    st_next.irq_any = st_next.irq_stat && st_next.irq_mask;
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.option <= TMZ_OPTION_RST;
      st_reg.intctl <= TMZ_INTCTL_RST;
      st_reg.count <= TMZ_COUNT_RST;
      // sample flops start at the folded idle level: no false edge after reset
      st_reg.ps_out_q2 <= 1'b1;
      st_reg.ps_out_q4 <= 1'b1;
      st_reg.ps_prev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign rdata_o = st_reg.rdata;
  assign timer_irq_o = st_reg.irq;
  assign watchdog_tick_o = st_reg.wdt_tick;
  assign irq_o = st_reg.irq_any;

  // assertions: count, overflow and flag
  a_overflow_sets_flag: assert property (@(posedge clk_i) disable iff (!rst_n) // R1
    ovf |=> st_reg.intctl[TMZ_IC_FLAG])
    else $error("overflow did not set flag");
  a_overflow_wraps: assert property (@(posedge clk_i) disable iff (!rst_n) // R1
    ovf |=> st_reg.count == TMZ_ZERO8)
    else $error("overflow did not wrap to zero");
  a_write_inhibit: assert property (@(posedge clk_i) disable iff (!rst_n) // R3
    wr_count |=> st_reg.inhibit == TMZ_INHIBIT_CYCLES)
    else $error("no inhibit after write");
  a_no_count_inhibit: assert property (@(posedge clk_i) disable iff (!rst_n) // R3
    (st_reg.inhibit != 2'h0 && !wr_count) |=> st_reg.count == $past(st_reg.count))
    else $error("count moved while inhibited");
  a_inhibit_runs_down: assert property (@(posedge clk_i) disable iff (!rst_n) // R3
    (st_reg.inhibit != 2'h0 && cyc_end && !wr_count) |=> st_reg.inhibit == $past(st_reg.inhibit) - 2'h1)
    else $error("inhibit did not run down");
  a_sleep_stops: assert property (@(posedge clk_i) disable iff (!rst_n) // R14
    (sleep_i && !wr_count) |=> $stable(st_reg.count))
    else $error("count moved in sleep");
  a_timer_mode_rate: assert property (@(posedge clk_i) disable iff (!rst_n) // R2
    (!cs && prescaler_assign && cyc_end && st_reg.inhibit == 2'h0 && !sleep_i && !bus.wr) |=> st_reg.count == $past(st_reg.count) + 8'h01)
    else $error("timer mode missed count");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_n) // R13
    (st_reg.intctl[TMZ_IC_FLAG] && !bus.wr) |=> st_reg.intctl[TMZ_IC_FLAG])
    else $error("flag cleared by hardware");
  // assertions: interrupt levels and read path
  a_irq_gating: assert property (@(posedge clk_i) disable iff (!rst_n) // R12
    timer_irq_o == (st_reg.intctl[TMZ_IC_FLAG] && st_reg.intctl[TMZ_IC_EN]))
    else $error("timer irq not flag and enable");
  a_status_sticky: assert property (@(posedge clk_i) disable iff (!rst_n) // R1
    (st_reg.irq_stat && !(bus.rd && reg_hit(bus, TMZ_OFS_IRQ_STAT))) |=> st_reg.irq_stat)
    else $error("status bit lost without a read");
  a_read_idle_zero: assert property (@(posedge clk_i) disable iff (!rst_n) // R8
    !bus.rd |=> rdata_o == TMZ_ZERO8)
    else $error("read data outside the read slot");
  // assertions: the shared prescaler
  a_write_clears_pre: assert property (@(posedge clk_i) disable iff (!rst_n) // R10
    (wr_count && !prescaler_assign) |=> st_reg.prescale == TMZ_ZERO8)
    else $error("prescaler not cleared");
  a_wdt_clears_pre: assert property (@(posedge clk_i) disable iff (!rst_n) // R11
    (watchdog_clear_instr_i && prescaler_assign) |=> st_reg.prescale == TMZ_ZERO8)
    else $error("watchdog clear missed prescaler");
  a_pre_steps: assert property (@(posedge clk_i) disable iff (!rst_n) // R16
    (pre_step && !clr_pre) |=> st_reg.prescale == $past(st_reg.prescale) + 8'h01)
    else $error("prescaler missed a step");
  a_pre_holds: assert property (@(posedge clk_i) disable iff (!rst_n) // R8
    (!pre_step && !clr_pre) |=> $stable(st_reg.prescale))
    else $error("prescaler moved without a step");
  a_wdt_owner_tick: assert property (@(posedge clk_i) disable iff (!rst_n) // R7
    !prescaler_assign |=> watchdog_tick_o == $past(cyc_end))
    else $error("watchdog tick wrong without prescaler");
  a_wdt_tick_pulse: assert property (@(posedge clk_i) disable iff (!rst_n) // R7
    watchdog_tick_o |=> !watchdog_tick_o)
    else $error("watchdog tick longer than one clock");
  // assertions: pin sampling
  a_sample_phase: assert property (@(posedge clk_i) disable iff (!rst_n) // R5
    !(in_q2 || in_q4) |=> $stable(st_reg.ps_out_q2) && $stable(st_reg.ps_out_q4))
    else $error("sample taken off its phase");
  a_ext_tick_phase: assert property (@(posedge clk_i) disable iff (!rst_n) // R5
    (cs && !(in_q2 || in_q4)) |-> !tick)
    else $error("counter mode step off a sample phase");
  a_pin_pass: assert property (@(posedge clk_i) disable iff (!rst_n) // R6
    (cs && prescaler_assign && in_q2) |=> st_reg.ps_out_q2 == $past(src_lvl))
    else $error("pin not passed through");
  c_overflow: cover property (@(posedge clk_i) disable iff (!rst_n) ovf);
  c_irq: cover property (@(posedge clk_i) disable iff (!rst_n) timer_irq_o);
  c_ext_count: cover property (@(posedge clk_i) disable iff (!rst_n) cs && tick);
  c_wdt_clear: cover property (@(posedge clk_i) disable iff (!rst_n) prescaler_assign && clr_pre);
  c_prescaled: cover property (@(posedge clk_i) disable iff (!rst_n) !prescaler_assign && tick);
endmodule

// ---- dv/tmz_pin_src.sv ----
/*
  count pin source: sends n whole pulses, then leaves the pin at a chosen idle level.
  assumes requests come one at a time on clk_i and wait for busy_o to fall.
*/
`timescale 1ns/1ps
module tmz_pin_src (
  // clock and request
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [4:0] n_i,
  input wire logic idle_i,
  // pin side
  output logic busy_o,
  output logic pin_o
);
  // each level held twelve clocks so both phase samples catch it
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (start_i) begin
        busy_o <= 1'b1;
        repeat (12) @(posedge clk_i);
        for (int i = 0; i < n_i; i++) begin
          pin_o <= 1'b1;
          repeat (12) @(posedge clk_i);
          pin_o <= 1'b0;
          repeat (12) @(posedge clk_i);
        end
        pin_o <= idle_i;
        repeat (12) @(posedge clk_i);
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// ---- dv/tmz_timer0_test.sv ----
/*
  self-checking bench for the timer0 block over its register port.
  assumes the pin source model on the count pin and a 125 MHz clock.
*/
`timescale 1ns/1ps
module tmz_timer0_test import tmz_pkg::*;;
  logic clk, resetn, wr, rd, slp, wclr, tirq, wtick, irq, pin, p_go, p_idle, p_busy;
  logic [7:0] addr, wdata, rdata, v, w;
  logic [4:0] p_n;
  int n_errors, n_compared, k, t;
  tmz_timer0 dut_u (.clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_count_input_i(pin), .sleep_i(slp),
    .watchdog_clear_instr_i(wclr), .timer_irq_o(tirq), .watchdog_tick_o(wtick), .irq_o(irq));
  tmz_pin_src src_u (.clk_i(clk), .start_i(p_go), .n_i(p_n), .idle_i(p_idle),
    .busy_o(p_busy), .pin_o(pin));
  // free-running 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic test_done;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // bounded wait, then slack for the pin synchroniser
  task automatic pulses(input logic [4:0] n, input logic idle);
    @(posedge clk);
    p_n <= n; p_idle <= idle; p_go <= 1'b1;
    @(posedge clk);
    p_go <= 1'b0;
    repeat (2) @(posedge clk);
    t = 0;
    while (p_busy === 1'b1 && t < 600) begin
      @(posedge clk);
      t++;
    end
    if (t >= 600) begin
      n_errors++;
      $display("Error at %0t: pin source hung", $time);
      test_done;
    end
    repeat (16) @(posedge clk);
  endtask
  task automatic ticks(input int c, output int n);
    n = 0;
    repeat (c) begin
      @(posedge clk);
      #1 if (wtick === 1'b1) n++;
    end
  endtask
  // main sequence
  initial begin
    resetn = 1'b0; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0; slp = 1'b0;
    wclr = 1'b0; p_go = 1'b0; p_n = 5'h00; p_idle = 1'b0; n_errors = 0; n_compared = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(TMZ_OFS_OPTION, v); chk(v, TMZ_OPTION_RST);
    rd_reg(TMZ_OFS_INTCTL, v); chk(v, TMZ_INTCTL_RST);
    rd_reg(8'h55, v); chk(v, TMZ_ZERO8);
    for (k = 0; k < 2; k++) begin
      wr_reg(TMZ_OFS_OPTION, (k != 0) ? 8'h38 : 8'h28);
      wr_reg(TMZ_OFS_COUNT, TMZ_ZERO8);
      pulses(5'h00, 1'b1); rd_reg(TMZ_OFS_COUNT, v); chk(v, (k != 0) ? 8'h00 : 8'h01);
      pulses(5'h00, 1'b0); rd_reg(TMZ_OFS_COUNT, v); chk(v, 8'h01);
    end
    for (k = 0; k < 3; k++) begin
      wr_reg(TMZ_OFS_OPTION, 8'h20 | 8'(k));
      wr_reg(TMZ_OFS_COUNT, TMZ_ZERO8);
      pulses(5'(4 << k), 1'b0); rd_reg(TMZ_OFS_COUNT, v); chk(v, 8'h02);
    end
    wr_reg(TMZ_OFS_OPTION, 8'h08);
    wr_reg(TMZ_OFS_COUNT, 8'h10);
    repeat (15) @(posedge clk);
    rd_reg(TMZ_OFS_COUNT, v);
    if (v !== 8'h11 && v !== 8'h12 && v !== 8'h13) chk(v, 8'h12);
    else n_compared++;
    rd_reg(TMZ_OFS_COUNT, v); repeat (38) @(posedge clk); rd_reg(TMZ_OFS_COUNT, w);
    chk(8'(w - v), 8'h0A);
    wr_reg(TMZ_OFS_IRQ_MASK, 8'h01);
    wr_reg(TMZ_OFS_COUNT, 8'hFE);
    t = 0; v = 8'h00;
    while (v[TMZ_IC_FLAG] !== 1'b1 && t < 20) begin
      rd_reg(TMZ_OFS_INTCTL, v);
      t++;
    end
    chk(v, 8'h04);
    chk({7'h00, irq}, 8'h01); chk({7'h00, tirq}, 8'h00);
    wr_reg(TMZ_OFS_INTCTL, 8'h24); repeat (2) @(posedge clk);
    chk({7'h00, tirq}, 8'h01);
    wr_reg(TMZ_OFS_INTCTL, 8'h04); repeat (2) @(posedge clk);
    chk({7'h00, tirq}, 8'h00);
    rd_reg(TMZ_OFS_IRQ_STAT, v); chk(v, 8'h01); repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    rd_reg(TMZ_OFS_INTCTL, v); chk(v, 8'h04);
    wr_reg(TMZ_OFS_INTCTL, 8'h00);
    slp <= 1'b1;
    repeat (2) @(posedge clk);
    rd_reg(TMZ_OFS_COUNT, v); repeat (20) @(posedge clk); rd_reg(TMZ_OFS_COUNT, w);
    chk(w, v);
    slp <= 1'b0;
    ticks(80, t); chk(8'(t), 8'h14);
    wr_reg(TMZ_OFS_OPTION, 8'h0B);
    @(posedge clk);
    wclr <= 1'b1;
    @(posedge clk);
    wclr <= 1'b0;
    ticks(24, t); chk(8'(t), 8'h00);
    test_done;
  end
endmodule
